// >>> design/sbe_pkg.sv
// Shared constants and types of the secure bus encryptor
package sbe_pkg;

  // Widths
  localparam int KEY_W     = 64;
  localparam int LA_W      = 16;
  localparam int PA_W      = 17;
  localparam int VEC_BYTES = 48;
  localparam int XF_ROUNDS = 4;

  // External bus cycle: four mclk cycles, count 0..3
  localparam logic [1:0] ACC_WE_ON  = 2'h0;
  localparam logic [1:0] ACC_WE_OFF = 2'h2;
  localparam logic [1:0] ACC_LAST   = 2'h3;

  // Redundant lock latch patterns; any other code means the latch was disturbed
  localparam logic [3:0] LOCK_SET = 4'hA;
  localparam logic [3:0] LOCK_CLR = 4'h5;

  // Random generator: 64 sampled bits make the 8-byte candidate
  localparam logic [6:0] RNG_LAST = 7'h3F;

  // Dummy address sequence
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // Bus power removal after tamper
  localparam int         CLK_NS       = 40;
  localparam int         PWR_OFF_NS   = 1000;
  localparam int         PWR_OFF_CYC  = PWR_OFF_NS / CLK_NS;
  localparam logic [4:0] PWR_OFF_LAST = 5'(PWR_OFF_CYC - 1);

  typedef enum logic [1:0] {
    M_RUN   = 2'b00,
    M_WIPE  = 2'b01,
    M_REKEY = 2'b10
  } sbe_mode_t;

endpackage : sbe_pkg

// >>> design/sbe_xform.sv
// Key-dependent address permutation and data pad, purely combinational
module sbe_xform
  import sbe_pkg::*;
(
  // Key and logical access
  input  wire logic [KEY_W-1:0] key,
  input  wire logic [LA_W-1:0]  laddr,
  input  wire logic             space,
  // Transformed results
  output logic      [PA_W-1:0]  paddr,
  output logic      [7:0]       pad
);

  function automatic logic [7:0] sbe_round(input logic [7:0] x, input logic [7:0] k);
    logic [7:0] t;
    t = x ^ k;
    return {t[4:0], t[7:5]} ^ (t + 8'h5B) ^ (t & {t[0], t[7:1]});
  endfunction : sbe_round

  logic [7:0] lh [0:XF_ROUNDS];
  logic [7:0] rh [0:XF_ROUNDS];

  assign lh[0] = laddr[15:8];
  assign rh[0] = laddr[7:0];

  // Feistel rounds stay invertible whatever the round function does
  for (genvar i = 0; i < XF_ROUNDS; i++)
  begin : g_round
    assign lh[i+1] = rh[i];
    assign rh[i+1] = lh[i] ^ sbe_round(rh[i], key[16*i +: 8]);  // R2
  end

  assign paddr = {space, lh[XF_ROUNDS], rh[XF_ROUNDS]};  // R1
  // XOR pad is its own inverse, so one pad serves writes and reads
  assign pad = sbe_round(laddr[7:0] ^ key[15:8], key[31:24])
             ^ sbe_round(laddr[15:8] ^ key[47:40], key[63:56]);  // R6

endmodule : sbe_xform

// >>> design/sbe_rng.sv
// Random key candidate from two ring oscillators sampled by mclk
module sbe_rng
  import sbe_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Oscillator pins
  input  wire logic             ring_osc_a,
  input  wire logic             ring_osc_b,
  // Control and result
  input  wire logic             start,
  output logic      [KEY_W-1:0] word,
  output logic                  valid
);

  typedef struct packed {
    logic             a1;
    logic             a2;
    logic             b1;
    logic             b2;
    logic             run;
    logic             valid;
    logic [6:0]       cnt;
    logic [KEY_W-1:0] word;
  } sbe_rng_st_t;

  sbe_rng_st_t s_q, s_d;

  always_comb
  begin
    s_d    = s_q;
    s_d.a1 = ring_osc_a;
    s_d.a2 = s_q.a1;
    s_d.b1 = ring_osc_b;
    s_d.b2 = s_q.b1;
    if (start)
    begin
      s_d.run   = 1'b1;
      s_d.valid = 1'b0;
      s_d.cnt   = '0;
    end
    else if (s_q.run)
    begin
      // Beat between the two oscillators and mclk gives the entropy
      s_d.word = {s_q.word[KEY_W-2:0], s_q.a2 ^ s_q.b2 ^ s_q.word[KEY_W-1]};  // R13
      s_d.cnt  = s_q.cnt + 7'h01;
      if (s_q.cnt == RNG_LAST)
      begin
        s_d.run   = 1'b0;
        s_d.valid = 1'b1;  // R23
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign word  = s_q.word;
  assign valid = s_q.valid;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_RNG_FILL: assert property (start |-> ##[65:66] valid)  // R23
    else $error("Key candidate not ready 64 samples after start");
  AST_RNG_STALE: assert property (start |=> !valid)  // R23
    else $error("Old key candidate still offered after restart");

endmodule : sbe_rng

// >>> design/sbe_top.sv
// Secure bus encryptor: CPU to external SRAM bus with scrambling and lock
//
// Summary of operation
// R1 - Physical bus address comes from the 64-bit key and logical address.
// R2 - Address map is one-to-one; no two logical addresses share a location.
// R3 - Scrambling covers the whole configured byte-wide range.
// R4 - Written byte is encrypted from key, logical address and true data.
// R5 - Every byte read back is decrypted before the CPU sees it.
// R6 - Data transform is deterministic and depends on address and key.
// R7 - Both transforms are active during loading and during execution.
// R8 - Idle bus during execution gets pseudorandom dummy reads; data is discarded.
// R9 - Dummy and real reads follow one repeatable, indistinguishable pattern.
// R10 - Dummy bus reads continue while vectors come from on-chip storage.
// R11 - Encryption is always on; nothing can bypass it.
// R12 - Key is never user-chosen; loader commands load it from the generator.
// R13 - Random bits come from two ring oscillators beating against mclk.
// R14 - Reset and interrupt vectors live in a 48-byte on-chip memory.
// R15 - Vector fetch at address 0000H never shows its address on the bus.
// R16 - Vector memory fills automatically while code is loaded.
// R17 - With the lock set, loader accesses to true contents are blocked.
// R18 - Lock set and clear only by loader commands; clear erases the key. Tamper and a disturbed latch also clear it here.
// R19 - Clearing the lock erases the whole vector memory at once.
// R20 - After erasure the external area is wiped, then a fresh key loads.
// R21 - Redundant lock latch; any disturbance starts an unstoppable erase.
// R22 - Tamper input clears lock, erases all and drops bus power briefly.
// R23 - Loader entry generates eight random bytes as key candidate.
// R24 - Encryption adds no cycles to the bus access.
module sbe_top
  import sbe_pkg::*;
#(
  parameter int WIPE_WORDS = 32768
)
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // CPU access port
  input  wire logic            cpu_req,
  input  wire logic            cpu_we,
  input  wire logic            cpu_prog,
  input  wire logic [LA_W-1:0] cpu_addr,
  input  wire logic [7:0]      cpu_wdata,
  output logic                 cpu_ready,
  output logic                 cpu_ack,
  output logic                 cpu_denied,
  output logic      [7:0]      cpu_rdata,
  // Loader control and status
  input  wire logic            loader_mode,
  input  wire logic [LA_W-1:0] range_limit,
  input  wire logic            loader_entry,
  input  wire logic            cmd_lock_set,
  input  wire logic            cmd_lock_clear,
  input  wire logic            cmd_key_load,
  output logic                 lock_active,
  output logic                 erase_busy,
  // Random source and tamper pins
  input  wire logic            ring_osc_a,
  input  wire logic            ring_osc_b,
  input  wire logic            tamper_erase_input,
  output logic                 vcco_off,
  // External SRAM bus
  output logic      [PA_W-1:0] ext_addr,
  output logic      [7:0]      ext_dout,
  output logic                 ext_doe,
  input  wire logic [7:0]      ext_din,
  output logic                 ext_ce_n,
  output logic                 ext_we_n
);

  typedef struct packed {
    sbe_mode_t                   mode;
    logic [3:0]                  lock;
    logic [KEY_W-1:0]            key;
    logic [VEC_BYTES-1:0][7:0]   vec;
    logic                        tmp1;
    logic                        tmp2;
    logic [7:0]                  din1;
    logic [7:0]                  din2;
    logic                        bbusy;
    logic [1:0]                  bcnt;
    logic                        bwrite;
    logic                        breal;
    logic                        bvec;
    logic [5:0]                  vidx;
    logic [7:0]                  pad;
    logic [15:0]                 lfsr;
    logic [LA_W-1:0]             wipe_addr;
    logic [4:0]                  pwr_cnt;
    logic                        rng_go;
    logic                        ready;
    logic                        ack;
    logic                        denied;
    logic [7:0]                  rdata;
    logic                        lock_stat;
    logic                        busy;
    logic                        vcco_off;
    logic [PA_W-1:0]             addr;
    logic [7:0]                  dout;
    logic                        doe;
    logic                        ce_n;
    logic                        we_n;
  } sbe_st_t;

  function automatic logic [15:0] sbe_lfsr_step(input logic [15:0] v);
    return {v[14:0], ^(v & LFSR_TAPS)};
  endfunction : sbe_lfsr_step

  sbe_st_t          s_q, s_d;
  logic             rst_m, rst_n;
  logic [PA_W-1:0]  xf_paddr;
  logic [7:0]       xf_pad;
  logic [KEY_W-1:0] rng_word;
  logic             rng_valid;
  logic             lock_on, lock_bad, take, deny, vec_hit, vec_rd, erase, dummy_go;
  logic [PA_W-1:0]  lfsr_pa;
  logic [LA_W-1:0]  wipe_last;

  // Reset is asserted at once and released through two flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // CPU addresses and data reach the bus only through the transform; no bypass exists
  sbe_xform u_xform (
    .key   (s_q.key),
    .laddr (cpu_addr),
    .space (cpu_prog),
    .paddr (xf_paddr),
    .pad   (xf_pad)
  );  // R11

  sbe_rng u_rng (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ring_osc_a (ring_osc_a),
    .ring_osc_b (ring_osc_b),
    .start      (s_q.rng_go),
    .word       (rng_word),
    .valid      (rng_valid)
  );

  assign lock_on   = s_q.lock == LOCK_SET;
  assign lock_bad  = !lock_on && (s_q.lock != LOCK_CLR);
  assign take      = cpu_req && s_q.ready;
  assign deny      = (loader_mode && lock_on) || (cpu_addr > range_limit);  // R17
  assign vec_hit   = cpu_prog && (cpu_addr < LA_W'(VEC_BYTES));
  assign vec_rd    = vec_hit && !cpu_we && !loader_mode;
  assign dummy_go  = s_q.ready && !cpu_req && !loader_mode;  // R8
  assign lfsr_pa   = {^s_q.lfsr[3:0], s_q.lfsr};
  assign wipe_last = LA_W'(WIPE_WORDS - 1);
  // Tamper and a disturbed latch are ignored mid-wipe; a bad latch code, or a tamper input still held, acts once the wipe ends
  assign erase     = (s_q.mode != M_WIPE)
                   && ((loader_mode && cmd_lock_clear && lock_on) || s_q.tmp2 || lock_bad);

  always_comb
  begin
    s_d        = s_q;
    s_d.tmp1   = tamper_erase_input;
    s_d.tmp2   = s_q.tmp1;
    s_d.din1   = ext_din;
    s_d.din2   = s_q.din1;
    s_d.ack    = 1'b0;
    s_d.denied = 1'b0;
    s_d.rng_go = 1'b0;
    if (s_q.vcco_off)
    begin
      if (s_q.pwr_cnt == 5'h00)
        s_d.vcco_off = 1'b0;
      else
        s_d.pwr_cnt = s_q.pwr_cnt - 5'h01;
    end
    if (s_q.bbusy)
    begin
      s_d.bcnt = s_q.bcnt + 2'h1;
      if (s_q.bcnt == ACC_WE_ON)
        s_d.we_n = !s_q.bwrite;
      if (s_q.bcnt == ACC_WE_OFF)
        s_d.we_n = 1'b1;
      if (s_q.bcnt == ACC_LAST)
      begin
        s_d.bbusy = 1'b0;
        s_d.ce_n  = 1'b1;
        s_d.doe   = 1'b0;
        if (s_q.breal)
        begin
          s_d.ack = 1'b1;
          if (s_q.bvec)
            s_d.rdata = s_q.vec[s_q.vidx];  // R14
          else if (s_q.bwrite)
            s_d.rdata = 8'h00;
          else
            s_d.rdata = s_q.din2 ^ s_q.pad;  // R5
        end
        if (s_q.mode == M_WIPE)
        begin
          if (s_q.wipe_addr == wipe_last)
          begin
            s_d.mode   = M_REKEY;
            s_d.rng_go = 1'b1;  // R20
          end
          else
            s_d.wipe_addr = s_q.wipe_addr + 16'h0001;
        end
      end
    end
    else if (s_q.mode == M_WIPE)
    begin
      // Clear the encrypted area one location at a time
      s_d.bbusy  = 1'b1;
      s_d.bcnt   = '0;
      s_d.bwrite = 1'b1;
      s_d.breal  = 1'b0;
      s_d.bvec   = 1'b0;
      s_d.addr   = {1'b0, s_q.wipe_addr};  // R20
      s_d.dout   = 8'h00;
      s_d.doe    = 1'b1;
      s_d.ce_n   = 1'b0;
    end
    else if (s_q.mode == M_REKEY)
    begin
      // Skip the cycle in which the generator has not yet dropped its old word
      if (!s_q.rng_go && rng_valid)
      begin
        s_d.key  = rng_word;  // R20
        s_d.mode = M_RUN;
      end
    end
    else if (take && deny)
    begin
      s_d.ack    = 1'b1;
      s_d.rdata  = 8'h00;  // R17
      s_d.denied = loader_mode && lock_on;
    end
    else if (take)
    begin
      // Same transform whether loading or executing
      s_d.bbusy  = 1'b1;  // R7
      s_d.bcnt   = '0;
      s_d.bwrite = cpu_we;
      s_d.breal  = 1'b1;
      s_d.bvec   = 1'b0;
      s_d.pad    = xf_pad;  // R24
      s_d.addr   = xf_paddr;  // R3
      s_d.dout   = cpu_wdata ^ xf_pad;  // R4
      s_d.doe    = cpu_we;
      s_d.ce_n   = 1'b0;
      if (vec_rd)
      begin
        // Vector comes from inside; the bus sees a dummy read of the same shape
        s_d.bvec = 1'b1;  // R15
        s_d.vidx = cpu_addr[5:0];
        s_d.addr = lfsr_pa;  // R10
        s_d.lfsr = sbe_lfsr_step(s_q.lfsr);
      end
      if (vec_hit && cpu_we && loader_mode)
        s_d.vec[cpu_addr[5:0]] = cpu_wdata;  // R16
    end
    else if (dummy_go)
    begin
      // Same length and strobes as a real read; the deterministic LFSR keeps it repeatable
      s_d.bbusy  = 1'b1;  // R9
      s_d.bcnt   = '0;
      s_d.bwrite = 1'b0;
      s_d.breal  = 1'b0;  // R8
      s_d.bvec   = 1'b0;
      s_d.addr   = lfsr_pa;
      s_d.ce_n   = 1'b0;
      s_d.lfsr   = sbe_lfsr_step(s_q.lfsr);
    end
    if (loader_mode && (s_q.mode == M_RUN))
    begin
      if (cmd_lock_set && !lock_on)
        s_d.lock = LOCK_SET;  // R18
      if (loader_entry)
        s_d.rng_go = 1'b1;  // R23
      if (cmd_key_load && !lock_on && rng_valid && !s_q.rng_go)
        s_d.key = rng_word;  // R12
    end
    if (erase)
    begin
      s_d.key       = '0;  // R18
      s_d.vec       = '0;  // R19
      s_d.lock      = LOCK_CLR;  // R21
      s_d.mode      = M_WIPE;
      s_d.wipe_addr = '0;
      s_d.bbusy     = 1'b0;
      s_d.ce_n      = 1'b1;
      s_d.we_n      = 1'b1;
      s_d.doe       = 1'b0;
      s_d.ack       = 1'b0;
      s_d.rng_go    = 1'b0;
      if (s_q.tmp2)
      begin
        s_d.vcco_off = 1'b1;  // R22
        s_d.pwr_cnt  = PWR_OFF_LAST;
      end
    end
    s_d.ready     = (s_d.mode == M_RUN) && !s_d.bbusy;
    s_d.lock_stat = s_d.lock == LOCK_SET;
    s_d.busy      = s_d.mode != M_RUN;
  end

  // The lock latch resets to its cleared code; a real part keeps it on backup power
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q      <= '0;
      s_q.lock <= LOCK_CLR;
      s_q.lfsr <= LFSR_SEED;
      s_q.ce_n <= 1'b1;
      s_q.we_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign cpu_ready   = s_q.ready;
  assign cpu_ack     = s_q.ack;
  assign cpu_denied  = s_q.denied;
  assign cpu_rdata   = s_q.rdata;
  assign lock_active = s_q.lock_stat;
  assign erase_busy  = s_q.busy;
  assign vcco_off    = s_q.vcco_off;
  assign ext_addr    = s_q.addr;
  assign ext_dout    = s_q.dout;
  assign ext_doe     = s_q.doe;
  assign ext_ce_n    = s_q.ce_n;
  assign ext_we_n    = s_q.we_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_ACK_TIME: assert property (take && !deny |-> ##5 (cpu_ack || erase_busy))  // R24
    else $error("Accepted access not answered five cycles later");
  AST_ADDR_MAP: assert property (take && !deny && !vec_rd && !erase
                                 |=> ext_addr == $past(xf_paddr) && !ext_ce_n)  // R1
    else $error("Bus address is not the transformed logical address");
  AST_WR_DATA: assert property (take && !deny && cpu_we && !erase
                                |=> ext_doe && ext_dout == ($past(cpu_wdata) ^ $past(xf_pad)))  // R4
    else $error("Written byte is not the encrypted value");
  AST_DENY: assert property (take && loader_mode && lock_on && !erase
                             |=> cpu_ack && cpu_denied && cpu_rdata == 8'h00 && ext_ce_n)  // R17
    else $error("Locked access was not blocked");
  AST_VEC_HIDE: assert property (take && !deny && vec_rd && !erase
                                 |=> !ext_ce_n && ext_we_n && ext_addr == $past(lfsr_pa))  // R10
    else $error("Vector fetch did not run a dummy bus read");
  AST_DUMMY: assert property (dummy_go && !erase
                              |=> !ext_ce_n && ext_we_n ##4 !cpu_ack)  // R8
    else $error("Idle bus without a discarded dummy read");
  AST_ERASE: assert property (erase
                              |=> s_q.key == '0 && s_q.vec == '0 && erase_busy && !lock_active)  // R19
    else $error("Lock clear did not erase key and vectors");
  AST_TAMPER: assert property (s_q.tmp2 && s_q.mode != M_WIPE
                               |=> vcco_off && !lock_active)  // R22
    else $error("Tamper input did not clear lock and cut bus power");
  AST_LATCH: assert property (lock_bad && s_q.mode != M_WIPE |=> s_q.mode == M_WIPE)  // R21
    else $error("Disturbed lock latch did not start the erase");
  AST_WIPE_HOLD: assert property (s_q.mode == M_WIPE && s_q.wipe_addr != wipe_last
                                  |=> s_q.mode == M_WIPE)  // R21
    else $error("Erase sequence left early");
  AST_KEY_SRC: assert property ($changed(s_q.key) && s_q.key != '0
                                |-> $past(rng_valid) && s_q.key == $past(rng_word))  // R12
    else $error("Key loaded from somewhere other than the generator");

  COV_DUMMY: cover property (dummy_go ##5 take);
  COV_VEC: cover property (take && vec_rd && !deny);
  COV_REKEY: cover property (s_q.mode == M_WIPE ##1 s_q.mode == M_REKEY);
  COV_TAMPER: cover property (s_q.tmp2 && s_q.mode == M_RUN);

endmodule : sbe_top

// >>> sim/sbe_sram.sv
// Byte-wide SRAM model on the far side of the scrambled bus
module sbe_sram
(
  // Bus from the encryptor
  input  wire logic        mclk,
  input  wire logic [16:0] ext_addr,
  input  wire logic [7:0]  ext_dout,
  input  wire logic        ext_doe,
  input  wire logic        ext_ce_n,
  input  wire logic        ext_we_n,
  input  wire logic        vcco_off,
  // Data back to the encryptor
  output logic      [7:0]  ext_din
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:131071];
  logic [7:0] junk;
  initial
  begin
    junk = 8'h3C;
    for (int i = 0; i < 131072; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  end
  // Unselected pins never show stale data, so the design cannot lean on it
  always @(posedge mclk)
  begin
    junk <= ~junk + 8'h01;
    if (vcco_off)
      for (int i = 0; i < 131072; i++)
        mem[i] <= junk;
    else if (!ext_ce_n && !ext_we_n && ext_doe)
      mem[ext_addr] <= ext_dout;
  end
  always_comb
    ext_din = (!ext_ce_n && ext_we_n) ? mem[ext_addr] : junk;
endmodule : sbe_sram

// >>> sim/secure_bus_encryptor_bench.sv
// Self-checking bench of the secure bus encryptor
module secure_bus_encryptor_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sbe_pkg::*;
  logic mclk, resetn, cpu_req, cpu_we, cpu_prog, cpu_ready, cpu_ack, cpu_denied;
  logic loader_mode, loader_entry, cmd_lock_set, cmd_lock_clear, cmd_key_load;
  logic lock_active, erase_busy, ring_osc_a, ring_osc_b, tamper_erase_input;
  logic vcco_off, ext_doe, ext_ce_n, ext_we_n, leak, watch;
  logic [LA_W-1:0] cpu_addr, range_limit;
  logic [PA_W-1:0] ext_addr, wa, vphys;
  logic [7:0] cpu_wdata, cpu_rdata, ext_dout, ext_din, wd, rd, s0, s1;
  logic dn;
  int n_fail, cmp_count, n_bus, b0, n;
  logic [15:0] la [8];
  logic [7:0] dv [8];
  logic [7:0] vb [4];
  logic [PA_W-1:0] pa [8];

  sbe_top #(.WIPE_WORDS(4)) sbe_top_i (.mclk, .resetn, .cpu_req, .cpu_we, .cpu_prog,
    .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_ack, .cpu_denied, .cpu_rdata, .loader_mode,
    .range_limit, .loader_entry, .cmd_lock_set, .cmd_lock_clear, .cmd_key_load,
    .lock_active, .erase_busy, .ring_osc_a, .ring_osc_b, .tamper_erase_input,
    .vcco_off, .ext_addr, .ext_dout, .ext_doe, .ext_din, .ext_ce_n, .ext_we_n);
  sbe_sram sbe_sram_i (.mclk, .ext_addr, .ext_dout, .ext_doe, .ext_ce_n, .ext_we_n,
    .vcco_off, .ext_din);

  always #20 mclk = ~mclk;
  always #7.3 ring_osc_a = ~ring_osc_a;
  always #11.9 ring_osc_b = ~ring_osc_b;

  // Bus monitor: counts bus accesses, records writes, flags a vector address leak
  logic ce_q;
  always @(posedge mclk)
  begin
    ce_q <= ext_ce_n;
    if (ce_q && !ext_ce_n)
      n_bus <= n_bus + 1;
    if (!ext_we_n)
    begin
      wa <= ext_addr;
      wd <= ext_dout;
    end
    if (watch && !ext_ce_n && ext_addr === vphys)
      leak <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One CPU access; lat is the number of cycles from take to answer
  task automatic acc(input logic w, input logic p, input logic [15:0] a,
                     input logic [7:0] d, input int lat);
    int k;
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_we = w;
    cpu_prog = p;
    cpu_addr = a;
    cpu_wdata = d;
    k = 0;
    while (cpu_ready !== 1'b1 && k < 50)
    begin
      @(negedge mclk);
      k++;
    end
    k = 0;
    do
    begin
      @(negedge mclk);
      cpu_req = 1'b0;
      k++;
    end while (cpu_ack !== 1'b1 && k < 20);
    chk(k, lat);
    rd = cpu_rdata;
    dn = cpu_denied;
  endtask : acc

  task automatic cmd(input logic [3:0] v);
    @(negedge mclk);
    {loader_entry, cmd_lock_set, cmd_lock_clear, cmd_key_load} = v;
    @(negedge mclk);
    {loader_entry, cmd_lock_set, cmd_lock_clear, cmd_key_load} = 4'h0;
  endtask : cmd

  task automatic wait_erase();
    n = 0;
    while (erase_busy !== 1'b0 && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(erase_busy, 0);
  endtask : wait_erase

  task automatic test_done();
    $display("errors %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    #(40 * 30000);
    n_fail++;
    test_done();
  end

  initial
  begin
    n = $urandom(32'h17c0);
    {mclk, resetn, cpu_req, cpu_we, cpu_prog, tamper_erase_input} = 6'h00;
    {loader_entry, cmd_lock_set, cmd_lock_clear, cmd_key_load} = 4'h0;
    {ring_osc_a, ring_osc_b, watch, leak, ce_q} = 5'h01;
    {cpu_addr, cpu_wdata, n_fail, cmp_count, n_bus} = '0;
    loader_mode = 1'b1;
    range_limit = 16'hFFFF;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    // Internal reset copy needs two edges; a command before that is lost
    repeat (3) @(negedge mclk);
    cmd(4'h8);
    repeat (100) @(negedge mclk);
    cmd(4'h1);
    chk(sbe_top_i.s_q.key != '0, 1);
    for (int i = 0; i < 8; i++)
    begin
      la[i] = 16'h0100 + 16'(i) * 16'h0800 + 16'($urandom_range(0, 255));
      dv[i] = 8'($urandom);
      acc(1'b1, 1'b0, la[i], dv[i], 5);
      pa[i] = wa;
      chk(pa[i][16], 0);
      for (int j = 0; j < i; j++)
        chk(pa[i] != pa[j], 1);
    end
    // Same byte twice at each of three addresses; one pad may collide, not all
    n = 0;
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, 1'b0, 16'h0031 + 16'(i / 2), 8'h5A, 5);
      if (i % 2 == 1)
        chk(wd, s1);
      else if (i == 0)
        s0 = wd;
      else
        n += int'(wd != s0);
      s1 = wd;
    end
    chk(n > 0, 1);
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, 1'b0, la[i], 8'h00, 5);
      chk(rd, dv[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      vb[i] = 8'($urandom);
      acc(1'b1, 1'b1, 16'(i), vb[i], 5);
      if (i == 0)
        vphys = wa;
    end
    loader_mode = 1'b0;
    b0 = n_bus;
    repeat (20) @(negedge mclk);
    chk(n_bus - b0 > 2, 1);
    watch = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      b0 = n_bus;
      acc(1'b0, 1'b1, 16'(i), 8'h00, 5);
      chk(rd, vb[i]);
      chk(n_bus > b0, 1);
    end
    watch = 1'b0;
    chk(leak, 0);
    acc(1'b0, 1'b0, la[2], 8'h00, 5);
    chk(rd, dv[2]);
    acc(1'b1, 1'b0, la[3], ~dv[3], 5);
    acc(1'b0, 1'b0, la[3], 8'h00, 5);
    chk(rd, 8'(~dv[3]));
    range_limit = 16'h7FFF;
    acc(1'b0, 1'b0, 16'h7FFF, 8'h00, 5);
    acc(1'b0, 1'b0, 16'h8000, 8'h00, 1);
    chk({dn, rd}, 9'h000);
    range_limit = 16'hFFFF;
    loader_mode = 1'b1;
    cmd(4'h4);
    chk(lock_active, 1);
    acc(1'b0, 1'b0, la[0], 8'h00, 1);
    chk({dn, rd}, 9'h100);
    cmd(4'h2);
    chk(lock_active, 0);
    chk(erase_busy, 1);
    wait_erase();
    for (int j = 0; j < 4; j++)
      chk(sbe_sram_i.mem[j], 0);
    chk(sbe_top_i.s_q.key != '0, 1);
    loader_mode = 1'b0;
    acc(1'b0, 1'b1, 16'h0000, 8'h00, 5);
    chk(rd, 0);
    loader_mode = 1'b1;
    cmd(4'h4);
    chk(lock_active, 1);
    @(negedge mclk);
    tamper_erase_input = 1'b1;
    n = 0;
    while (vcco_off !== 1'b1 && n < 10)
    begin
      @(negedge mclk);
      n++;
    end
    tamper_erase_input = 1'b0;
    chk(vcco_off, 1);
    chk({lock_active, erase_busy}, 2'b01);
    wait_erase();
    test_done();
  end
endmodule : secure_bus_encryptor_bench
